/* bench/host_link_model.sv */
`timescale 1ns/1ps

// Host controller side of the link: it owns the serial clock and chip select.
module host_link_model (
  output logic o_sclk,
  output logic o_cs_n
);
  // The clock is parked low and the device deselected between frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end

  // Selects the device; the frame has no data lines here, so nothing contends.
  task automatic open_frame();
    o_cs_n = 1'b0;
  endtask

  // Gives n serial clocks at 160 ns; t_abort gives 3 for a count of 8 to cut the frame short.
  task automatic clocks(input int n);
    for (int k = 0; k < n; k++) begin
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
  endtask

  // Ends the frame with the clock still parked, so no stray edge is seen.
  task automatic close_frame();
    o_cs_n = 1'b1;
  endtask
endmodule // host_link_model

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "dummy_sel_regs.svh"

module testbench;
  // ------------------------------------------------------------
  // Stimulus, observed outputs and counters
  // ------------------------------------------------------------
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_dummy_start = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic i_quad_command_mode = 1'b0;
  logic i_param_wr = 1'b0;
  logic i_param_persist = 1'b0;
  logic [3:0] i_param_data = 4'h0;
  logic sclk, cs_n, o_data_oe, o_dummy_active, o_cmd_reject;
  logic [3:0] o_dummy_count, o_param_volatile, o_param_persist;
  int mismatches = 0;
  int checked = 0;

  // The 50 MHz core clock.
  always #10 i_core_clk = ~i_core_clk;

  host_link_model host_u (.o_sclk(sclk), .o_cs_n(cs_n));

  read_dummy_cycle_select dut_u (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_dummy_start(i_dummy_start), .i_opcode(i_opcode),
    .i_quad_command_mode(i_quad_command_mode), .i_param_wr(i_param_wr),
    .i_param_persist(i_param_persist), .i_param_data(i_param_data), .o_data_oe(o_data_oe),
    .o_dummy_active(o_dummy_active), .o_cmd_reject(o_cmd_reject),
    .o_dummy_count(o_dummy_count), .o_param_volatile(o_param_volatile),
    .o_param_persist(o_param_persist));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares with case equality so an unknown never matches.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits at most 20 cycles for the data enable to reach v.
  task automatic wait_oe(input logic v);
    for (int k = 0; k < 20; k++) begin
      @(negedge i_core_clk);
      if (o_data_oe === v) return;
    end
    mismatches++;
    $display("CHECK FAILED at %0t: data enable wait ran out", $time);
    results();
  endtask

  // One write of the dummy field; a gap cycle keeps repeated calls apart.
  task automatic wr_param(input logic persist, input logic [3:0] data);
    @(negedge i_core_clk);
    i_param_wr = 1'b1;
    i_param_persist = persist;
    i_param_data = data;
    @(negedge i_core_clk);
    i_param_wr = 1'b0;
  endtask

  // Opens a frame and starts a read command.
  task automatic start(input logic [7:0] op, input logic quad);
    host_u.open_frame();
    repeat (3) @(negedge i_core_clk);
    i_dummy_start = 1'b1;
    i_opcode = op;
    i_quad_command_mode = quad;
    @(negedge i_core_clk);
    i_dummy_start = 1'b0;
  endtask

  // A whole read: the enable must stay low until exactly exp clocks have passed.
  task automatic read_frame(input logic [7:0] op, input logic quad, input logic [3:0] exp);
    start(op, quad);
    check(o_dummy_active, 1'b1);
    check(o_dummy_count, exp);
    host_u.clocks(int'(exp) - 1);
    repeat (4) @(negedge i_core_clk);
    check(o_data_oe, 1'b0);
    check(o_dummy_active, 1'b1);
    host_u.clocks(1);
    wait_oe(1'b1);
    check(o_dummy_active, 1'b0);
    host_u.close_frame();
    wait_oe(1'b0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Every read command with the field at zero, each in one or both command modes.
  task automatic t_defaults();
    logic [7:0] ops [23] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0b, 8'h0e, 8'h3b, 8'h3c,
      8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'h6b, 8'h6c, 8'heb, 8'hec, 8'hed, 8'hee, 8'h4b,
      8'h64, 8'h4b, 8'hbb, 8'h64};
    logic qd [23] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [3:0] ex [23] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h6, 4'h6, 4'h8, 4'h8, 4'h4, 4'h4,
      4'h4, 4'h4, 4'h8, 4'h8, 4'h6, 4'h6, 4'h6, 4'h6, 4'h8, 4'h8, 4'h6, 4'h4, 4'h6};
    for (int k = 0; k < 23; k++) begin
      read_frame(ops[k], qd[k], ex[k]);
    end
  endtask

  // Programmed counts at both ends of the range, then back to the default.
  task automatic t_program();
    wr_param(1'b0, 4'h1);
    check(o_param_volatile, 4'h1);
    read_frame(8'h0b, 1'b0, 4'h1);
    wr_param(1'b0, 4'hf);
    read_frame(8'heb, 1'b1, 4'hf);
    wr_param(1'b1, 4'h9);
    check(o_param_persist, 4'h9);
    check(o_param_volatile, 4'hf);
    wr_param(1'b0, 4'h0);
    read_frame(8'hbb, 1'b0, 4'h4);
  endtask

  // A frame cut in the dummy phase never drives, and the next read counts afresh.
  task automatic t_abort();
    start(`OP_QUAD_OUT, 1'b0);
    host_u.clocks(3);
    host_u.close_frame();
    repeat (5) @(negedge i_core_clk);
    check(o_dummy_active, 1'b0);
    check(o_data_oe, 1'b0);
    read_frame(`OP_QUAD_OUT, 1'b0, 4'h8);
  endtask

  // Double-rate dual read in quad mode is refused; an unknown opcode is ignored.
  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      start((k == 0) ? `OP_DUAL_IO_DR : `OP_DUAL_IO_DR_4B, 1'b1);
      check(o_cmd_reject, 1'b1);
      check(o_dummy_active, 1'b0);
      @(negedge i_core_clk);
      check(o_cmd_reject, 1'b0);
      check(o_data_oe, 1'b0);
      host_u.close_frame();
      repeat (4) @(negedge i_core_clk);
    end
    start(8'h03, 1'b0);
    check(o_dummy_active, 1'b0);
    check(o_cmd_reject, 1'b0);
    host_u.close_frame();
    repeat (4) @(negedge i_core_clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence: reset for 8 cycles, reset values, then scenarios.
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge i_core_clk);
    check(o_param_volatile, 4'h0);
    check(o_param_persist, 4'h0);
    check(o_data_oe, 1'b0);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_core_clk);
    t_defaults();
    t_program();
    t_abort();
    t_refuse();
    results();
  end
endmodule // testbench

/* rtl/dummy_count_lookup.sv */
`timescale 1ns/1ps
`include "dummy_sel_regs.svh"

// Combinational map from command, mode and register field to a dummy count.
module dummy_count_lookup #(
  parameter logic [7:0] OP_UNIQUE_ID = 8'h4b, // Value is arbitrary.
  parameter logic [7:0] OP_INFO_ROW = 8'h64 // Value is arbitrary.
) (
  dummy_sel_if.table_side lk
);

  // --------------------------------------------------------------------------
  // Default count per command
  // --------------------------------------------------------------------------
  // Decode runs on every cycle; the sequencer only samples it at the start.
  always_comb begin
    logic [`DSEL_CNT_W-1:0] def;
    def = `DSEL_USE_DEFAULT;
    lk.known = 1'b1;
    lk.reject = 1'b0;
    case (lk.opcode)
      `OP_FAST_READ, `OP_FAST_READ_4B, `OP_FAST_READ_DR, `OP_FAST_READ_DR_4B,
      OP_UNIQUE_ID, OP_INFO_ROW: begin
        // Identifier and information-row reads share the fast read defaults. [R7]
        def = lk.quad_mode ? `DSEL_DEF_FAST_QUAD : `DSEL_DEF_FAST_SPI; // [R2]
      end
      `OP_DUAL_OUT, `OP_DUAL_OUT_4B: begin
        def = `DSEL_DEF_DUAL_OUT; // [R3]
      end
      `OP_DUAL_IO, `OP_DUAL_IO_4B: begin
        def = `DSEL_DEF_DUAL_IO; // [R4]
      end
      `OP_DUAL_IO_DR, `OP_DUAL_IO_DR_4B: begin
        def = `DSEL_DEF_DUAL_IO; // [R4]
        // The double-rate dual read exists only with single-line commands. [R11]
        lk.reject = lk.quad_mode;
      end
      `OP_QUAD_OUT, `OP_QUAD_OUT_4B: begin
        def = `DSEL_DEF_QUAD_OUT; // [R5]
      end
      `OP_QUAD_IO, `OP_QUAD_IO_4B, `OP_QUAD_IO_DR, `OP_QUAD_IO_DR_4B: begin
        def = `DSEL_DEF_QUAD_IO; // [R6]
      end
      default: begin
        // Not a read that takes dummy cycles.
        lk.known = 1'b0;
      end
    endcase
    // Zero picks the default, anything else is taken literally. [R1]
    lk.count = (lk.param == `DSEL_USE_DEFAULT) ? def : lk.param;
  end

endmodule // dummy_count_lookup

/* rtl/dummy_sel_if.sv */
`timescale 1ns/1ps
`include "dummy_sel_regs.svh"

// Lookup request from the sequencer and the selected count coming back.
interface dummy_sel_if;
  logic [7:0] opcode;
  logic quad_mode;
  logic [`DSEL_CNT_W-1:0] param;
  logic [`DSEL_CNT_W-1:0] count;
  logic known;
  logic reject;

  modport requester (output opcode, output quad_mode, output param,
                     input count, input known, input reject);
  modport table_side (input opcode, input quad_mode, input param,
                      output count, output known, output reject);
endinterface

/* rtl/dummy_sel_pkg.sv */
`include "dummy_sel_regs.svh"

package dummy_sel_pkg;

  // Sequencer phases of one read command.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_DATA
  } phase_e;

  // Whole state of the top module, registered in one process.
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic csn_s1;
    logic csn_s2;
    phase_e phase;
    logic [`DSEL_CNT_W-1:0] remain;
    logic [`DSEL_CNT_W-1:0] nv_param;
    logic [`DSEL_CNT_W-1:0] vol_param;
    logic [`DSEL_CNT_W-1:0] count;
    logic data_oe;
    logic dummy_active;
    logic reject;
  } dsel_state_s;

endpackage

/* rtl/dummy_sel_regs.svh */
`ifndef DUMMY_SEL_REGS_SVH
`define DUMMY_SEL_REGS_SVH

// ----------------------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------------------
// Width of the dummy-count field of the read-parameter register.
`define DSEL_CNT_W 4
// Reset value of the persistent and the volatile dummy-count copies.
`define DSEL_PARAM_RST 4'h0
// Field value that selects the per-command default count.
`define DSEL_USE_DEFAULT 4'h0

// ----------------------------------------------------------------------------
// Per-command default dummy counts
// ----------------------------------------------------------------------------
`define DSEL_DEF_FAST_SPI 4'h8
`define DSEL_DEF_FAST_QUAD 4'h6
`define DSEL_DEF_DUAL_OUT 4'h8
`define DSEL_DEF_DUAL_IO 4'h4
`define DSEL_DEF_QUAD_OUT 4'h8
`define DSEL_DEF_QUAD_IO 4'h6

// ----------------------------------------------------------------------------
// Read command opcodes
// ----------------------------------------------------------------------------
`define OP_FAST_READ 8'h0b
`define OP_FAST_READ_4B 8'h0c
`define OP_FAST_READ_DR 8'h0d
`define OP_FAST_READ_DR_4B 8'h0e
`define OP_DUAL_OUT 8'h3b
`define OP_DUAL_OUT_4B 8'h3c
`define OP_DUAL_IO 8'hbb
`define OP_DUAL_IO_4B 8'hbc
`define OP_DUAL_IO_DR 8'hbd
`define OP_DUAL_IO_DR_4B 8'hbe
`define OP_QUAD_OUT 8'h6b
`define OP_QUAD_OUT_4B 8'h6c
`define OP_QUAD_IO 8'heb
`define OP_QUAD_IO_4B 8'hec
`define OP_QUAD_IO_DR 8'hed
`define OP_QUAD_IO_DR_4B 8'hee

`endif

/* rtl/read_dummy_cycle_select.sv */
// Summary of operation
// R1 - Zero selects default; 1..15 inserts exactly that.
// R2 - Fast read default 8, quad-command mode 6.
// R3 - Dual-output read default is 8 cycles.
// R4 - Dual-I/O read, both rates, default 4.
// R5 - Quad-output read default is 8 cycles.
// R6 - Quad-I/O read, all forms, default 6.
// R7 - Identifier and info-row reads follow fast read.
// R8 - Host programs count sufficient for its clock.
// R9 - Host: quad fast read 81MHz, 166MHz needs 14.
// R10 - Mode don't-care bits undriven, no line contention.
// R11 - Double-rate dual read refused in quad-command mode.
// R12 - Four register bits hold count, host-writable.
// R13 - Outputs released in dummy; drive after last.
`timescale 1ns/1ps
`include "dummy_sel_regs.svh"

module read_dummy_cycle_select (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_dummy_start,
  input wire logic [7:0] i_opcode,
  input wire logic i_quad_command_mode,
  input wire logic i_param_wr,
  input wire logic i_param_persist,
  input wire logic [`DSEL_CNT_W-1:0] i_param_data,
  output logic o_data_oe,
  output logic o_dummy_active,
  output logic o_cmd_reject,
  output logic [`DSEL_CNT_W-1:0] o_dummy_count,
  output logic [`DSEL_CNT_W-1:0] o_param_volatile,
  output logic [`DSEL_CNT_W-1:0] o_param_persist
);

  // --------------------------------------------------------------------------
  // State and lookup
  // --------------------------------------------------------------------------
  dummy_sel_pkg::dsel_state_s st; // Registered state.
  dummy_sel_pkg::dsel_state_s next_st; // Value for the next edge.
  logic sclk_rise; // One-cycle mark of a serial clock rising edge.
  logic go; // A dummy phase starts this cycle.

  // The interface keeps the lookup request and its answer together.
  dummy_sel_if lk_if ();

  // The lookup always sees the live volatile copy, so a register write is
  // effective for the very next command.
  assign lk_if.opcode = i_opcode;
  assign lk_if.quad_mode = i_quad_command_mode;
  assign lk_if.param = st.vol_param;

  // Purely combinational; its answer matters only in the cycle of a start.
  dummy_count_lookup u_lookup (
    .lk(lk_if.table_side)
  );

  // Edge found on the second and third stages only; the first stage feeds
  // nothing but the second, to keep metastability out of the decode.
  assign sclk_rise = st.sclk_s2 & ~st.sclk_s3;
  // A start while chip-select still reads high, or for an unknown opcode, is dropped.
  assign go = (st.phase == dummy_sel_pkg::ST_IDLE) & i_dummy_start & ~st.csn_s2 &
              lk_if.known & ~lk_if.reject;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sclk_s1 = i_sclk;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_s3 = st.sclk_s2;
    next_st.csn_s1 = i_cs_n;
    next_st.csn_s2 = st.csn_s1;
    next_st.reject = 1'b0;

    // Software-visible copies; only the volatile one feeds the lookup, and reset loads both with DSEL_PARAM_RST. [R12]
    if (i_param_wr && i_param_persist) begin
      next_st.nv_param = i_param_data;
    end
    if (i_param_wr && !i_param_persist) begin
      next_st.vol_param = i_param_data;
    end

    case (st.phase)
      dummy_sel_pkg::ST_IDLE: begin
        // Outputs stay released through address and mode bits. [R10]
        next_st.data_oe = 1'b0;
        if (go) begin
          // The working count and the copy shown to the host load together.
          next_st.phase = dummy_sel_pkg::ST_DUMMY;
          next_st.remain = lk_if.count; // [R1]
          next_st.count = lk_if.count;
          next_st.dummy_active = 1'b1;
        end else if (i_dummy_start && !st.csn_s2 && lk_if.reject) begin
          // Refused command: no dummy phase and no data drive. [R11]
          next_st.reject = 1'b1;
        end
      end
      dummy_sel_pkg::ST_DUMMY: begin
        // Lines stay high-impedance; the host may still float mode bits. [R13]
        if (sclk_rise) begin
          next_st.remain = st.remain - 4'h1;
          if (st.remain == 4'h1) begin
            // The last dummy edge hands the lines to read data. [R13]
            next_st.phase = dummy_sel_pkg::ST_DATA;
            next_st.dummy_active = 1'b0;
            next_st.data_oe = 1'b1;
          end
        end
      end
      dummy_sel_pkg::ST_DATA: begin
        // The data phase lasts until the host deselects the device.
        next_st.data_oe = 1'b1;
      end
      default: begin
        // An illegal phase code falls back to idle.
        next_st.phase = dummy_sel_pkg::ST_IDLE;
      end
    endcase

    // Chip-select going high ends the command whatever the phase.
    if (st.csn_s2) begin
      next_st.phase = dummy_sel_pkg::ST_IDLE;
      next_st.data_oe = 1'b0;
      next_st.dummy_active = 1'b0;
      next_st.remain = 4'h0;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Chip-select synchronisers reset to deselected so nothing starts early.
  // The serial clock stages reset to the parked level, so no false edge follows reset.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.csn_s1 <= 1'b1;
      st.csn_s2 <= 1'b1;
      st.nv_param <= `DSEL_PARAM_RST;
      st.vol_param <= `DSEL_PARAM_RST;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Every output is a field of the state register, so none can glitch.
  assign o_data_oe = st.data_oe;
  assign o_dummy_active = st.dummy_active;
  assign o_cmd_reject = st.reject;
  assign o_dummy_count = st.count;
  assign o_param_volatile = st.vol_param;
  assign o_param_persist = st.nv_param;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  logic fast_op; // Fast read or one of the reads sharing its defaults.
  assign fast_op = (i_opcode inside {`OP_FAST_READ, `OP_FAST_READ_4B, `OP_FAST_READ_DR,
                    `OP_FAST_READ_DR_4B, u_lookup.OP_UNIQUE_ID, u_lookup.OP_INFO_ROW});

  // Count selection: a nonzero field wins, otherwise the command's own default.
  a_nonzero_literal: assert property (go && st.vol_param != 4'h0 |=> // [R1]
    st.remain == $past(st.vol_param)) else $error("Nonzero field not used as count.");
  a_fast_spi_eight: assert property (go && st.vol_param == 4'h0 && fast_op && // [R2]
    !i_quad_command_mode |=> st.remain == 4'h8) else $error("Fast read default not 8.");
  a_fast_quad_six: assert property (go && st.vol_param == 4'h0 && fast_op && // [R2]
    i_quad_command_mode |=> st.remain == 4'h6) else $error("Quad fast read default not 6.");
  a_dual_out_eight: assert property (go && st.vol_param == 4'h0 && // [R3]
    i_opcode inside {`OP_DUAL_OUT, `OP_DUAL_OUT_4B} |=> st.remain == 4'h8)
    else $error("Dual output default not 8.");
  a_dual_io_four: assert property (go && st.vol_param == 4'h0 && // [R4]
    i_opcode inside {`OP_DUAL_IO, `OP_DUAL_IO_4B, `OP_DUAL_IO_DR, `OP_DUAL_IO_DR_4B}
    |=> st.remain == 4'h4) else $error("Dual I/O default not 4.");
  a_quad_out_eight: assert property (go && st.vol_param == 4'h0 && // [R5]
    i_opcode inside {`OP_QUAD_OUT, `OP_QUAD_OUT_4B} |=> st.remain == 4'h8)
    else $error("Quad output default not 8.");
  a_quad_io_six: assert property (go && st.vol_param == 4'h0 && // [R6]
    i_opcode inside {`OP_QUAD_IO, `OP_QUAD_IO_4B, `OP_QUAD_IO_DR, `OP_QUAD_IO_DR_4B}
    |=> st.remain == 4'h6) else $error("Quad I/O default not 6.");
  a_id_row_follow: assert property (go && st.vol_param == 4'h0 && // [R7]
    i_opcode == u_lookup.OP_INFO_ROW |=>
    st.remain == ($past(i_quad_command_mode) ? 4'h6 : 4'h8))
    else $error("Info row read not following fast read.");
  a_unique_id_follow: assert property (go && st.vol_param == 4'h0 && // [R7]
    i_opcode == u_lookup.OP_UNIQUE_ID |=>
    st.remain == ($past(i_quad_command_mode) ? 4'h6 : 4'h8))
    else $error("Unique identifier read not following fast read.");
  // Refusals and register writes.
  a_ddr_dual_refused: assert property (st.phase == dummy_sel_pkg::ST_IDLE && // [R11]
    i_dummy_start && !st.csn_s2 && i_quad_command_mode &&
    i_opcode inside {`OP_DUAL_IO_DR, `OP_DUAL_IO_DR_4B}
    |=> o_cmd_reject && !o_dummy_active ##1 !o_data_oe) else $error("Refused read started.");
  a_volatile_write: assert property (i_param_wr && !i_param_persist |=> // [R12]
    o_param_volatile == $past(i_param_data)) else $error("Volatile count not written.");
  a_persist_write: assert property (i_param_wr && i_param_persist |=> // [R12]
    o_param_persist == $past(i_param_data) && $stable(o_param_volatile))
    else $error("Persistent count not written alone.");
  a_reject_one_cycle: assert property (o_cmd_reject |=> !o_cmd_reject) // [R11]
    else $error("Refusal mark held for more than one cycle.");
  // Line ownership and count hold: the device drives only in the data phase.
  a_released_in_dummy: assert property (st.phase != dummy_sel_pkg::ST_DATA |-> // [R13]
    !o_data_oe) else $error("Data driven before the dummy phase ended.");
  a_drive_after_last: assert property (st.phase == dummy_sel_pkg::ST_DUMMY && // [R13]
    sclk_rise && st.remain == 4'h1 && !st.csn_s2 |=> o_data_oe && !o_dummy_active)
    else $error("Data not driven after the last dummy edge.");
  a_mode_bits_float: assert property (go |=> !o_data_oe [*2]) // [R10]
    else $error("Lines driven while mode bits may float.");
  a_hold_between_edges: assert property (st.phase == dummy_sel_pkg::ST_DUMMY && // [R1]
    !sclk_rise && !st.csn_s2 |=> st.remain == $past(st.remain) && o_dummy_active)
    else $error("Dummy count moved without a serial clock edge.");
  a_cs_ends_cmd: assert property (st.csn_s2 |=> !o_data_oe && !o_dummy_active) // [R13]
    else $error("Lines still driven after a deselect.");

  // Covers for the main scenarios: default and literal counts, refusal, abort.

  c_default_read: cover property (go && st.vol_param == 4'h0 ##[1:300] o_data_oe);
  c_literal_read: cover property (go && st.vol_param == 4'hf ##[1:600] o_data_oe);
  c_refused: cover property (o_cmd_reject);
  c_cs_abort: cover property (o_dummy_active ##1 st.csn_s2);

endmodule // read_dummy_cycle_select
